// file: common/ppc_regs.vh
/*
 * Offsets, field positions, reset values and timing figures of the
 * paged power control register group.
 * Assumes a 250 MHz core clock and byte-wide register access.
 */
`ifndef PPC_REGS_VH
`define PPC_REGS_VH

// ****************
// Register offsets
// ****************
`define PPC_OFF_PAGE_SELECT   8'h00
`define PPC_OFF_SOFT_RESET    8'h01
`define PPC_OFF_SLEEP_CFG     8'h02
`define PPC_OFF_SHUTDOWN_CFG  8'h05

// ****************
// Reset values
// ****************
`define PPC_RST_PAGE_SELECT   8'h00
`define PPC_RST_SOFT_RESET    8'h00
`define PPC_RST_SLEEP_CFG     8'h00
`define PPC_RST_SHUTDOWN_CFG  8'h05

// ****************
// Field positions
// ****************
`define PPC_SRST_BIT          0
`define PPC_SLP_RAIL_BIT      7
`define PPC_SLP_RSVD_HI       6
`define PPC_SLP_RSVD_LO       5
`define PPC_SLP_REFQC_HI      4
`define PPC_SLP_REFQC_LO      3
`define PPC_SLP_BCAST_BIT     2
`define PPC_SLP_EXIT_BIT      0
`define PPC_SHD_INQC_HI       5
`define PPC_SHD_INQC_LO       4
`define PPC_SHD_BEH_HI        3
`define PPC_SHD_BEH_LO        2
`define PPC_SHD_HOLD_HI       1
`define PPC_SHD_HOLD_LO       0

// Writable bits; all others read zero
`define PPC_MASK_SLEEP_CFG    8'hfd
`define PPC_MASK_SHUTDOWN_CFG 8'h3f

// ****************
// Shutdown pin behaviour codes
// ****************
`define PPC_SHD_IMMEDIATE     2'h0
`define PPC_SHD_TIMEOUT       2'h1
`define PPC_SHD_CLEAN         2'h2

// Fixed broadcast target address
`define PPC_BCAST_ADDR        7'h4c

// ****************
// Timing, microseconds, and clock rate
// ****************
`define PPC_CLK_MHZ           25'hfa
`define PPC_T_REFQC0_US       25'hdac
`define PPC_T_REFQC1_US       25'h2710
`define PPC_T_REFQC2_US       25'hc350
`define PPC_T_REFQC3_US       25'h186a0
`define PPC_T_HOLD0_US        25'h7530
`define PPC_T_HOLD1_US        25'h61a8
`define PPC_T_HOLD2_US        25'h2710
`define PPC_T_HOLD3_US        25'h1388
`define PPC_T_INQC0_US        25'h9c4
`define PPC_T_INQC1_US        25'h30d4
`define PPC_T_INQC2_US        25'h61a8
`define PPC_T_INQC3_US        25'hc350
`define PPC_CNT_W             25

`endif

// file: core/ppc_timer.v
/*
 * One-shot down counter for the quick-charge and hold intervals.
 * Assumes start is a one-cycle pulse on core_clk; load is at least 1.
 */
`include "ppc_regs.vh"

module ppc_timer (
  core_clk,
  blk_rst,
  start,
  load,
  busy,
  done
);
  input  wire                   core_clk;
  input  wire                   blk_rst;
  input  wire                   start;
  input  wire [`PPC_CNT_W-1:0]  load;
  output wire                   busy;
  output wire                   done;

  reg [`PPC_CNT_W-1:0] cnt_q;
  reg [`PPC_CNT_W-1:0] cnt_d;

  // ****************************************************************
  // Counter
  // ****************************************************************
  always @* begin
    cnt_d = cnt_q;
    if (start) begin
      cnt_d = load;
    end else if (cnt_q != {`PPC_CNT_W{1'b0}}) begin
      cnt_d = cnt_q - {{(`PPC_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge core_clk) begin
    if (blk_rst) begin
      cnt_q <= {`PPC_CNT_W{1'b0}};
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign busy = (cnt_q != {`PPC_CNT_W{1'b0}});
  // Last cycle of the interval
  assign done = (cnt_q == {{(`PPC_CNT_W-1){1'b0}}, 1'b1}) & ~start;

endmodule

// file: core/ppc_regs.v
/*
 * Paged power control registers: page select, self-clearing soft
 * reset, sleep configuration and shutdown configuration, plus the
 * quick-charge timers and shutdown-pin regulator sequencing.
 * Assumes a control-bus decoder on core_clk issues byte accesses;
 * address-select and shutdown pins are asynchronous.
 */
//
// Contract
// - Page register at 0x00 selects page
// - Page is 8-bit read/write, resets 0
// - Writing 1 resets all registers
// - Reset bit clears itself afterwards
// - Bit 7 picks external or internal rail
// - Reference quick-charge code picks four durations
// - Broadcast enable forces fixed target address
// - Otherwise target address follows select pins
// - Sleep bit 0 sleeps, 1 wakes
// - Shutdown register at 0x05, resets 5h
// - Behaviour code chooses regulator power-down action
// - Hold code chooses regulator keep-alive time
// - Input quick-charge code picks four durations
`include "ppc_regs.vh"

module ppc_regs #(
  parameter [`PPC_CNT_W-1:0] REFQC0_CYC = `PPC_T_REFQC0_US * `PPC_CLK_MHZ,
  parameter [`PPC_CNT_W-1:0] REFQC1_CYC = `PPC_T_REFQC1_US * `PPC_CLK_MHZ,
  parameter [`PPC_CNT_W-1:0] REFQC2_CYC = `PPC_T_REFQC2_US * `PPC_CLK_MHZ,
  parameter [`PPC_CNT_W-1:0] REFQC3_CYC = `PPC_T_REFQC3_US * `PPC_CLK_MHZ,
  parameter [`PPC_CNT_W-1:0] HOLD0_CYC  = `PPC_T_HOLD0_US * `PPC_CLK_MHZ,
  parameter [`PPC_CNT_W-1:0] HOLD1_CYC  = `PPC_T_HOLD1_US * `PPC_CLK_MHZ,
  parameter [`PPC_CNT_W-1:0] HOLD2_CYC  = `PPC_T_HOLD2_US * `PPC_CLK_MHZ,
  parameter [`PPC_CNT_W-1:0] HOLD3_CYC  = `PPC_T_HOLD3_US * `PPC_CLK_MHZ,
  parameter [`PPC_CNT_W-1:0] INQC0_CYC  = `PPC_T_INQC0_US * `PPC_CLK_MHZ,
  parameter [`PPC_CNT_W-1:0] INQC1_CYC  = `PPC_T_INQC1_US * `PPC_CLK_MHZ,
  parameter [`PPC_CNT_W-1:0] INQC2_CYC  = `PPC_T_INQC2_US * `PPC_CLK_MHZ,
  parameter [`PPC_CNT_W-1:0] INQC3_CYC  = `PPC_T_INQC3_US * `PPC_CLK_MHZ,
  // Arbitrary upper bits of the pin-derived target address
  parameter [4:0]            ADDR_BASE  = 5'h0a
) (
  core_clk,
  sys_rst,
  reg_wr_en,
  reg_rd_en,
  reg_addr,
  reg_wdata,
  reg_rdata,
  reg_hit,
  addr_sel_pins,
  shutdown_pin_n,
  clean_shutdown_done,
  page_select,
  soft_reset_pulse,
  analog_rail_source_sel,
  ref_cap_precharge_time,
  bus_broadcast_enable,
  sleep_exit_n,
  shutdown_pin_behavior,
  digital_reg_hold_time,
  input_cap_precharge_time,
  bus_target_addr,
  ref_cap_precharge_active,
  input_cap_precharge_active,
  digital_core_regulator_en
);
  input  wire        core_clk;
  input  wire        sys_rst;
  input  wire        reg_wr_en;
  input  wire        reg_rd_en;
  input  wire [7:0]  reg_addr;
  input  wire [7:0]  reg_wdata;
  output wire [7:0]  reg_rdata;
  output wire        reg_hit;
  input  wire [1:0]  addr_sel_pins;
  input  wire        shutdown_pin_n;
  input  wire        clean_shutdown_done;
  output wire [7:0]  page_select;
  output wire        soft_reset_pulse;
  output wire        analog_rail_source_sel;
  output wire [1:0]  ref_cap_precharge_time;
  output wire        bus_broadcast_enable;
  output wire        sleep_exit_n;
  output wire [1:0]  shutdown_pin_behavior;
  output wire [1:0]  digital_reg_hold_time;
  output wire [1:0]  input_cap_precharge_time;
  output wire [6:0]  bus_target_addr;
  output wire        ref_cap_precharge_active;
  output wire        input_cap_precharge_active;
  output wire        digital_core_regulator_en;

  localparam [1:0] ST_RUN        = 2'h0;
  localparam [1:0] ST_HOLD_TIMED = 2'h1;
  localparam [1:0] ST_HOLD_CLEAN = 2'h2;
  localparam [1:0] ST_OFF        = 2'h3;
  // Pins: [2] shutdown_pin_n (idle high), [1:0] address select
  localparam [2:0] PIN_RST       = 3'h4;

  reg  [7:0]            page_q;
  reg                   srst_q;
  reg  [7:0]            sleep_q;
  reg  [7:0]            shdn_q;
  reg  [7:0]            rdata_q;
  reg  [6:0]            taddr_q;
  reg                   wake_prev_q;
  reg                   shdn_prev_q;
  reg  [1:0]            reg_st_q;
  reg  [1:0]            reg_st_d;
  reg  [2:0]            pin_s1_q;
  reg  [2:0]            pin_s2_q;
  reg  [2:0]            pin_s3_q;
  reg  [2:0]            pin_q;
  wire                  blk_rst;
  wire                  on_page0;
  wire                  wr_page;
  wire                  wr_srst;
  wire                  wr_sleep;
  wire                  wr_shdn;
  wire [2:0]            pin_raw;
  wire                  wake_start;
  wire                  shdn_fall;
  wire                  shdn_rise;
  wire                  hold_done;
  wire [`PPC_CNT_W-1:0] refqc_load;
  wire [`PPC_CNT_W-1:0] inqc_load;
  wire [`PPC_CNT_W-1:0] hold_load;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function [`PPC_CNT_W-1:0] pick_time;
    input [1:0]            code;
    input [`PPC_CNT_W-1:0] t0;
    input [`PPC_CNT_W-1:0] t1;
    input [`PPC_CNT_W-1:0] t2;
    input [`PPC_CNT_W-1:0] t3;
    begin
      case (code)
        2'h0:    pick_time = t0;
        2'h1:    pick_time = t1;
        2'h2:    pick_time = t2;
        default: pick_time = t3;
      endcase
    end
  endfunction

  function hits;
    input [7:0] addr;
    input [7:0] off;
    input       pg0;
    begin
      // Page register answers on every page
      hits = (addr == off) &&
             (pg0 || (off == `PPC_OFF_PAGE_SELECT));
    end
  endfunction

  // Soft reset pulse returns all but the pin synchronisers to power-on values
  assign blk_rst  = sys_rst | srst_q;
  assign on_page0 = (page_q == 8'h00);
  assign wr_page  = reg_wr_en & hits(reg_addr, `PPC_OFF_PAGE_SELECT,
                                     on_page0);
  assign wr_srst  = reg_wr_en & hits(reg_addr, `PPC_OFF_SOFT_RESET,
                                     on_page0);
  assign wr_sleep = reg_wr_en & hits(reg_addr, `PPC_OFF_SLEEP_CFG,
                                     on_page0);
  assign wr_shdn  = reg_wr_en & hits(reg_addr, `PPC_OFF_SHUTDOWN_CFG,
                                     on_page0);
  assign reg_hit  = hits(reg_addr, `PPC_OFF_PAGE_SELECT, on_page0) |
                    hits(reg_addr, `PPC_OFF_SOFT_RESET, on_page0) |
                    hits(reg_addr, `PPC_OFF_SLEEP_CFG, on_page0) |
                    hits(reg_addr, `PPC_OFF_SHUTDOWN_CFG, on_page0);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  assign pin_raw = {shutdown_pin_n, addr_sel_pins};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      always @(posedge core_clk) begin
        if (sys_rst) begin
          pin_s1_q[gi] <= PIN_RST[gi];
          pin_s2_q[gi] <= PIN_RST[gi];
          pin_s3_q[gi] <= PIN_RST[gi];
          pin_q[gi]    <= PIN_RST[gi];
        end else begin
          pin_s1_q[gi] <= pin_raw[gi];
          pin_s2_q[gi] <= pin_s1_q[gi];
          pin_s3_q[gi] <= pin_s2_q[gi];
          // Change accepted once stages two and three agree
          if (pin_s2_q[gi] == pin_s3_q[gi]) begin
            pin_q[gi] <= pin_s3_q[gi];
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Registers
  // ****************************************************************
  always @(posedge core_clk) begin
    if (sys_rst) begin
      srst_q <= 1'b0;
    end else if (srst_q) begin
      srst_q <= 1'b0;
    end else if (wr_srst && reg_wdata[`PPC_SRST_BIT]) begin
      srst_q <= 1'b1;
    end
  end

  always @(posedge core_clk) begin
    if (blk_rst) begin
      page_q  <= `PPC_RST_PAGE_SELECT;
      sleep_q <= `PPC_RST_SLEEP_CFG;
      shdn_q  <= `PPC_RST_SHUTDOWN_CFG;
    end else begin
      if (wr_page) begin
        page_q <= reg_wdata;
      end
      if (wr_sleep) begin
        // Bit 1 is read-only and stays zero
        sleep_q <= reg_wdata & `PPC_MASK_SLEEP_CFG;
      end
      if (wr_shdn) begin
        shdn_q <= reg_wdata & `PPC_MASK_SHUTDOWN_CFG;
      end
    end
  end

  // Read data registered one cycle after the request
  always @(posedge core_clk) begin
    if (blk_rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_en) begin
      if (hits(reg_addr, `PPC_OFF_PAGE_SELECT, on_page0)) begin
        rdata_q <= page_q;
      end else if (hits(reg_addr, `PPC_OFF_SOFT_RESET, on_page0)) begin
        rdata_q <= {7'h00, srst_q};
      end else if (hits(reg_addr, `PPC_OFF_SLEEP_CFG, on_page0)) begin
        rdata_q <= sleep_q;
      end else if (hits(reg_addr, `PPC_OFF_SHUTDOWN_CFG, on_page0)) begin
        rdata_q <= shdn_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  // ****************************************************************
  // Target address
  // ****************************************************************
  always @(posedge core_clk) begin
    if (blk_rst) begin
      taddr_q <= {ADDR_BASE, PIN_RST[1:0]};
    end else if (sleep_q[`PPC_SLP_BCAST_BIT]) begin
      taddr_q <= `PPC_BCAST_ADDR;
    end else begin
      taddr_q <= {ADDR_BASE, pin_q[1:0]};
    end
  end

  // ****************************************************************
  // Quick-charge timers
  // ****************************************************************
  assign wake_start = sleep_q[`PPC_SLP_EXIT_BIT] & ~wake_prev_q;
  assign refqc_load = pick_time(
    sleep_q[`PPC_SLP_REFQC_HI:`PPC_SLP_REFQC_LO],
    REFQC0_CYC, REFQC1_CYC, REFQC2_CYC, REFQC3_CYC);
  assign inqc_load  = pick_time(
    shdn_q[`PPC_SHD_INQC_HI:`PPC_SHD_INQC_LO],
    INQC0_CYC, INQC1_CYC, INQC2_CYC, INQC3_CYC);
  assign hold_load  = pick_time(
    shdn_q[`PPC_SHD_HOLD_HI:`PPC_SHD_HOLD_LO],
    HOLD0_CYC, HOLD1_CYC, HOLD2_CYC, HOLD3_CYC);

  ppc_timer u_refqc (
    .core_clk (core_clk),
    .blk_rst  (blk_rst),
    .start    (wake_start),
    .load     (refqc_load),
    .busy     (ref_cap_precharge_active),
    .done     ()
  );

  ppc_timer u_inqc (
    .core_clk (core_clk),
    .blk_rst  (blk_rst),
    .start    (wake_start),
    .load     (inqc_load),
    .busy     (input_cap_precharge_active),
    .done     ()
  );

  // ****************************************************************
  // Shutdown sequencing of the digital core regulator
  // ****************************************************************
  assign shdn_fall = shdn_prev_q & ~pin_q[2];
  assign shdn_rise = ~shdn_prev_q & pin_q[2];

  ppc_timer u_hold (
    .core_clk (core_clk),
    .blk_rst  (blk_rst),
    .start    (shdn_fall),
    .load     (hold_load),
    .busy     (),
    .done     (hold_done)
  );

  always @(posedge core_clk) begin
    if (blk_rst) begin
      wake_prev_q <= 1'b0;
      shdn_prev_q <= 1'b1;
      reg_st_q    <= ST_RUN;
    end else begin
      wake_prev_q <= sleep_q[`PPC_SLP_EXIT_BIT];
      shdn_prev_q <= pin_q[2];
      reg_st_q    <= reg_st_d;
    end
  end

  always @* begin
    reg_st_d = reg_st_q;
    case (reg_st_q)
      ST_RUN: begin
        if (shdn_fall) begin
          case (shdn_q[`PPC_SHD_BEH_HI:`PPC_SHD_BEH_LO])
            `PPC_SHD_TIMEOUT: reg_st_d = ST_HOLD_TIMED;
            `PPC_SHD_CLEAN:   reg_st_d = ST_HOLD_CLEAN;
            default:          reg_st_d = ST_OFF;
          endcase
        end
      end
      ST_HOLD_TIMED: begin
        if (shdn_rise) begin
          reg_st_d = ST_RUN;
        end else if (hold_done || clean_shutdown_done) begin
          reg_st_d = ST_OFF;
        end
      end
      ST_HOLD_CLEAN: begin
        if (shdn_rise) begin
          reg_st_d = ST_RUN;
        end else if (clean_shutdown_done) begin
          reg_st_d = ST_OFF;
        end
      end
      ST_OFF: begin
        if (shdn_rise) begin
          reg_st_d = ST_RUN;
        end
      end
      default: reg_st_d = ST_RUN;
    endcase
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata                 = rdata_q;
  assign page_select               = page_q;
  assign soft_reset_pulse          = srst_q;
  assign analog_rail_source_sel    = sleep_q[`PPC_SLP_RAIL_BIT];
  assign ref_cap_precharge_time    =
    sleep_q[`PPC_SLP_REFQC_HI:`PPC_SLP_REFQC_LO];
  assign bus_broadcast_enable      = sleep_q[`PPC_SLP_BCAST_BIT];
  assign sleep_exit_n              = sleep_q[`PPC_SLP_EXIT_BIT];
  assign shutdown_pin_behavior     =
    shdn_q[`PPC_SHD_BEH_HI:`PPC_SHD_BEH_LO];
  assign digital_reg_hold_time     =
    shdn_q[`PPC_SHD_HOLD_HI:`PPC_SHD_HOLD_LO];
  assign input_cap_precharge_time  =
    shdn_q[`PPC_SHD_INQC_HI:`PPC_SHD_INQC_LO];
  assign bus_target_addr           = taddr_q;
  assign digital_core_regulator_en = (reg_st_q != ST_OFF);

endmodule

// file: verif/ppc_regs_checker.sv
/* Assertions on the ports of the paged power control registers.
   Assumes one core_clk domain and a synchronous active-high reset. */
`include "ppc_regs.vh"

module ppc_regs_checker #(
  parameter [`PPC_CNT_W-1:0] REFQC0_CYC = 25'ha,
  parameter [`PPC_CNT_W-1:0] INQC0_CYC  = 25'he,
  parameter [4:0]            ADDR_BASE  = 5'h0a
) (
  input wire                 core_clk,
  input wire                 sys_rst,
  input wire                 reg_wr_en,
  input wire                 reg_rd_en,
  input wire [7:0]           reg_addr,
  input wire [7:0]           reg_wdata,
  input wire [7:0]           reg_rdata,
  input wire                 reg_hit,
  input wire [1:0]           addr_sel_pins,
  input wire                 shutdown_pin_n,
  input wire                 clean_shutdown_done,
  input wire [7:0]           page_select,
  input wire                 soft_reset_pulse,
  input wire                 analog_rail_source_sel,
  input wire [1:0]           ref_cap_precharge_time,
  input wire                 bus_broadcast_enable,
  input wire                 sleep_exit_n,
  input wire [1:0]           shutdown_pin_behavior,
  input wire [1:0]           digital_reg_hold_time,
  input wire [1:0]           input_cap_precharge_time,
  input wire [6:0]           bus_target_addr,
  input wire                 ref_cap_precharge_active,
  input wire                 input_cap_precharge_active,
  input wire                 digital_core_regulator_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Helper logic
  // ****************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [`PPC_CNT_W-1:0] ref_run_q;
  logic [`PPC_CNT_W-1:0] in_run_q;
  wire                   wr_ok = reg_wr_en && reg_hit && !soft_reset_pulse;
  // Length of the current high run of each quick-charge flag
  always @(posedge core_clk) begin
    ref_run_q <= ref_cap_precharge_active ? ref_run_q + 25'h1 : 25'h0;
    in_run_q  <= input_cap_precharge_active ? in_run_q + 25'h1 : 25'h0;
  end
  sequence s_srst_req;
    wr_ok && reg_addr == `PPC_OFF_SOFT_RESET && reg_wdata[0];
  endsequence
  sequence s_fall_hold;
    $fell(shutdown_pin_n) && shutdown_pin_behavior == 2'h1 &&
      digital_reg_hold_time == 2'h1;
  endsequence
  sequence s_clean_wait;
    $fell(shutdown_pin_n) && shutdown_pin_behavior == 2'h2 ##1
      (!clean_shutdown_done && !shutdown_pin_n)[*8];
  endsequence
  // ****************
  // Assertions
  // ****************
  a_reset_state: assert property (disable iff (1'b0)
    sys_rst |=> page_select == 8'h00 && !sleep_exit_n &&
      shutdown_pin_behavior == 2'h1 && digital_reg_hold_time == 2'h1 &&
      input_cap_precharge_time == 2'h0 && digital_core_regulator_en)
    else $error("reset state wrong");
  a_soft_reset: assert property (s_srst_req |=> soft_reset_pulse
    ##1 !soft_reset_pulse && page_select == 8'h00 && !sleep_exit_n &&
      shutdown_pin_behavior == 2'h1)
    else $error("soft reset sequence wrong");
  a_page_write: assert property (reg_wr_en && reg_addr == 8'h00 &&
    !soft_reset_pulse |=> page_select == $past(reg_wdata))
    else $error("page write lost");
  a_sleep_write: assert property (wr_ok &&
    reg_addr == `PPC_OFF_SLEEP_CFG |=> {analog_rail_source_sel,
      ref_cap_precharge_time, bus_broadcast_enable, sleep_exit_n} ==
      $past({reg_wdata[7], reg_wdata[4:2], reg_wdata[0]}))
    else $error("sleep fields wrong");
  a_shd_write: assert property (wr_ok &&
    reg_addr == `PPC_OFF_SHUTDOWN_CFG |=>
      {input_cap_precharge_time, shutdown_pin_behavior,
       digital_reg_hold_time} == $past(reg_wdata[5:0]))
    else $error("shutdown fields wrong");
  a_rsvd_zero: assert property (reg_rd_en && reg_hit &&
    reg_addr == `PPC_OFF_SHUTDOWN_CFG |=> reg_rdata[7:6] == 2'h0)
    else $error("reserved bits not zero");
  a_unmapped_rd: assert property (reg_rd_en && !reg_hit |=>
    reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_bcast_addr: assert property (bus_broadcast_enable &&
    $past(bus_broadcast_enable) |-> bus_target_addr == `PPC_BCAST_ADDR)
    else $error("broadcast address wrong");
  a_pin_addr: assert property ((!bus_broadcast_enable &&
    $stable(addr_sel_pins))[*7] |->
      bus_target_addr == {ADDR_BASE, addr_sel_pins})
    else $error("pin address wrong");
  a_ref_length: assert property ($fell(ref_cap_precharge_active) &&
    ref_cap_precharge_time == 2'h0 |-> ref_run_q == REFQC0_CYC)
    else $error("reference quick-charge length wrong");
  a_inq_length: assert property ($fell(input_cap_precharge_active) &&
    input_cap_precharge_time == 2'h0 |-> in_run_q == INQC0_CYC)
    else $error("input quick-charge length wrong");
  a_shd_fast: assert property ($fell(shutdown_pin_n) &&
    shutdown_pin_behavior == 2'h0 |-> ##[2:8] !digital_core_regulator_en)
    else $error("immediate power-down late");
  a_shd_hold: assert property (s_fall_hold |->
    digital_core_regulator_en[*8] ##[10:22] !digital_core_regulator_en)
    else $error("hold time wrong");
  a_shd_clean: assert property (s_clean_wait |->
    digital_core_regulator_en)
    else $error("regulator dropped before clean shutdown");
endmodule

bind ppc_regs ppc_regs_checker #(.REFQC0_CYC(REFQC0_CYC),
  .INQC0_CYC(INQC0_CYC), .ADDR_BASE(ADDR_BASE)) i_ppc_regs_checker (
  .core_clk, .sys_rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
  .reg_rdata, .reg_hit, .addr_sel_pins, .shutdown_pin_n,
  .clean_shutdown_done, .page_select, .soft_reset_pulse,
  .analog_rail_source_sel, .ref_cap_precharge_time, .bus_broadcast_enable,
  .sleep_exit_n, .shutdown_pin_behavior, .digital_reg_hold_time,
  .input_cap_precharge_time, .bus_target_addr, .ref_cap_precharge_active,
  .input_cap_precharge_active, .digital_core_regulator_en);

// file: verif/ppc_host_model.sv
/* Host controller side of the byte strobe register port.
   Assumes the register block samples strobes on the rising core_clk. */
module ppc_host_model (
  input  wire        core_clk,
  input  wire [7:0]  reg_rdata,
  output logic       reg_wr_en,
  output logic       reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************************************
  // Accesses
  // ********************************************************
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // Released lines show the inverse so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    reg_addr  <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

// file: verif/paged_power_control_regs_bench.sv
/* Self-checking bench for the paged power control registers.
   Assumes the host model, the bound checker and short timer counts. */
module paged_power_control_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk;
  logic       sys_rst;
  logic       shutdown_pin_n;
  logic       clean_shutdown_done;
  logic [1:0] addr_sel_pins;
  wire        reg_wr_en, reg_rd_en, reg_hit, soft_reset_pulse;
  wire        analog_rail_source_sel, bus_broadcast_enable, sleep_exit_n;
  wire        ref_cap_precharge_active, input_cap_precharge_active;
  wire        digital_core_regulator_en;
  wire [7:0]  reg_addr, reg_wdata, reg_rdata, page_select;
  wire [1:0]  ref_cap_precharge_time, shutdown_pin_behavior;
  wire [1:0]  digital_reg_hold_time, input_cap_precharge_time;
  wire [6:0]  bus_target_addr;
  int         fail_count = 0;
  int         checked = 0;
  // ********************************************************
  // Instances and clock
  // ********************************************************
  ppc_regs #(.REFQC0_CYC(25'ha), .INQC0_CYC(25'he), .HOLD1_CYC(25'h14))
  i_ppc_regs (.core_clk, .sys_rst, .reg_wr_en, .reg_rd_en, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_hit, .addr_sel_pins, .shutdown_pin_n,
    .clean_shutdown_done, .page_select, .soft_reset_pulse,
    .analog_rail_source_sel, .ref_cap_precharge_time,
    .bus_broadcast_enable, .sleep_exit_n, .shutdown_pin_behavior,
    .digital_reg_hold_time, .input_cap_precharge_time, .bus_target_addr,
    .ref_cap_precharge_active, .input_cap_precharge_active,
    .digital_core_regulator_en);
  ppc_host_model i_ppc_host_model (.core_clk, .reg_rdata, .reg_wr_en,
    .reg_rd_en, .reg_addr, .reg_wdata);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // ********************************************************
  // Tasks
  // ********************************************************
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdchk(input string what, input logic [7:0] a,
                       input logic [7:0] exp);
    logic [7:0] d;
    i_ppc_host_model.rd(a, d);
    chk(what, exp, d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_ppc_host_model.wr(a, d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    print_verdict;
  end
  // ********************************************************
  // Tests
  // ********************************************************
  initial begin
    sys_rst = 1'b1;
    shutdown_pin_n = 1'b1;
    clean_shutdown_done = 1'b0;
    addr_sel_pins = 2'h0;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    cyc(1);
    rdchk("page", 8'h00, 8'h00);
    rdchk("soft reset", 8'h01, 8'h00);
    rdchk("sleep", 8'h02, 8'h00);
    rdchk("shutdown", 8'h05, 8'h05);
    chk("target addr", 8'h28, 8'(bus_target_addr));
    $display("test reset values done");
    wr(8'h00, 8'hff);
    rdchk("page", 8'h00, 8'hff);
    wr(8'h02, 8'h01);
    rdchk("sleep off page", 8'h02, 8'h00);
    wr(8'h00, 8'h00);
    rdchk("sleep", 8'h02, 8'h00);
    rdchk("unmapped", 8'h03, 8'h00);
    $display("test paging done");
    wr(8'h02, 8'h01);
    cyc(2);
    chk("ref active", 8'h01, 8'(ref_cap_precharge_active));
    chk("in active", 8'h01, 8'(input_cap_precharge_active));
    cyc(20);
    chk("ref idle", 8'h00, 8'(ref_cap_precharge_active));
    chk("in idle", 8'h00, 8'(input_cap_precharge_active));
    chk("awake", 8'h01, 8'(sleep_exit_n));
    @(posedge core_clk) addr_sel_pins <= 2'h3;
    wr(8'h02, 8'hff);
    rdchk("sleep", 8'h02, 8'hfd);
    chk("rail", 8'h01, 8'(analog_rail_source_sel));
    chk("ref code", 8'h03, 8'(ref_cap_precharge_time));
    cyc(8);
    chk("bcast addr", 8'h4c, 8'(bus_target_addr));
    wr(8'h02, 8'h01);
    cyc(8);
    chk("pin addr", 8'h2b, 8'(bus_target_addr));
    $display("test sleep config done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h05, {4'h0, 2'(c), 2'h1});
      @(posedge core_clk) shutdown_pin_n <= 1'b0;
      cyc(12);
      chk("reg early", 8'(c == 1 || c == 2),
          8'(digital_core_regulator_en));
      cyc(30);
      chk("reg late", 8'(c == 2), 8'(digital_core_regulator_en));
      if (c == 2) begin
        @(posedge core_clk) clean_shutdown_done <= 1'b1;
        @(posedge core_clk) clean_shutdown_done <= 1'b0;
        cyc(3);
        chk("reg clean", 8'h00, 8'(digital_core_regulator_en));
      end
      @(posedge core_clk) shutdown_pin_n <= 1'b1;
      cyc(8);
      chk("reg back", 8'h01, 8'(digital_core_regulator_en));
    end
    wr(8'h05, 8'hff);
    rdchk("shutdown", 8'h05, 8'h3f);
    $display("test shutdown done");
    wr(8'h02, 8'hff);
    wr(8'h01, 8'hfe);
    rdchk("no reset", 8'h02, 8'hfd);
    wr(8'h01, 8'h01);
    cyc(2);
    rdchk("soft reset", 8'h01, 8'h00);
    rdchk("sleep", 8'h02, 8'h00);
    rdchk("shutdown", 8'h05, 8'h05);
    $display("test soft reset done");
    print_verdict;
  end
endmodule
